// ---- design/pb_port_b_defs.svh ----
/*
  Constants for the port B pin control block: register byte offsets,
  implemented-bit masks, field positions and reset values.
  Assumes inclusion by bare name from the change detector and port B design modules.
*/
`ifndef PB_PORT_B_DEFS_SVH
`define PB_PORT_B_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PB_AXI_AW        8
`define PB_OFF_ANALOG    8'h00
`define PB_OFF_INTMAIN   8'h04
`define PB_OFF_INTSEC    8'h08
`define PB_OFF_INTTHIRD  8'h0c
`define PB_OFF_CHGEN     8'h10
`define PB_OFF_LATCH     8'h14
`define PB_OFF_LEVELS    8'h18
`define PB_OFF_SLEW      8'h1c
`define PB_OFF_DIR       8'h20
`define PB_OFF_PULLUP    8'h24
`define PB_OFF_FUSEREL   8'h28
`define PB_OFF_FUSEDBG   8'h2c
`define PB_OFF_IRQSTAT   8'h30
`define PB_OFF_IRQMASK   8'h34

// ****************************************
// Implemented-bit masks
// ****************************************
`define PB_MSK_ANALOG    8'h3f
`define PB_MSK_INTMAIN   8'hfe
`define PB_MSK_INTSEC    8'hf5
`define PB_MSK_INTTHIRD  8'hdb
`define PB_MSK_CHGEN     8'hf0
`define PB_MSK_SLEW_S    8'h07
`define PB_MSK_SLEW_L    8'h1f
`define PB_MSK_FUSEREL   8'hd3
`define PB_MSK_FUSEDBG   8'he1
`define PB_MSK_IRQ       8'h01

// ****************************************
// Field and pin positions
// ****************************************
`define PB_BIT_CHGIE     3
`define PB_BIT_CHGIF     0
`define PB_BIT_PUDIS     7
`define PB_BIT_SDOMUX    6
`define PB_BIT_T3MUX     4
`define PB_BIT_ANDEF     1
`define PB_BIT_CMP2MUX   0
`define PB_BIT_LVPEN     2
`define PB_PIN_SDO       3
`define PB_PIN_CMP2      3
`define PB_PIN_T3CLK     5
`define PB_PIN_PWM2      2
`define PB_PIN_PWM4      4
`define PB_IRQ_CHANGE    0

// ****************************************
// Reset values and responses
// ****************************************
`define PB_RST_ANALOG    8'h3f
`define PB_RST_DIR       8'hff
`define PB_RST_INTSEC    8'hf5
`define PB_RST_ZERO      8'h00
`define PB_RST_FUSEREL   8'hd3
`define PB_RST_FUSEDBG   8'h85
`define PB_RESP_OKAY     2'b00
`define PB_RESP_DECERR   2'b11

`endif

// ---- design/pb_pkg.sv ----
/*
  Types for the port B pin control block: bus channel state encodings.
  Assumes the constants header is on the include path.
*/
package pb_pkg;

  typedef enum logic [1:0] {
    PB_RD_IDLE = 2'b01,
    PB_RD_DATA = 2'b10
  } pb_rd_state_t;

  typedef enum logic [1:0] {
    PB_WR_IDLE = 2'b01,
    PB_WR_RESP = 2'b10
  } pb_wr_state_t;

endpackage

// ---- design/pb_pin_sync.sv ----
/*
  Three-stage synchroniser for asynchronous pin levels, one per bit.
  Assumes inputs come from outside the clk domain.
*/
`timescale 1ns/1ps
module pb_pin_sync
  import pb_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // ****************************************
  // Per-bit chain
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : gBit
      logic stage1;
      logic stage2;
      logic stage3;
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          stage1     <= 1'b0;
          stage2     <= 1'b0;
          stage3     <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
          stage3 <= stage2;
          // Accept only once two later stages agree
          if (stage2 == stage3)
            syncOut[i] <= stage3;
        end
      end
    end
  endgenerate

endmodule // pb_pin_sync

// ---- design/pb_change_detect.sv ----
/*
  Change detector for port B upper pins: holds the level seen at the last
  port access and flags any mismatch on enabled input pins.
  Assumes synchronised pin levels and single-cycle access pulses.
*/
`timescale 1ns/1ps
`include "pb_port_b_defs.svh"
module pb_change_detect
  import pb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] pinLevel,
  input  wire logic [7:0] direction,
  input  wire logic [7:0] changeEnable,
  input  wire logic       portAccess,
  output logic            mismatch
);

  logic [7:0] lastRead;
  logic [7:0] differ;

  // ****************************************
  // Old value captured at each port access
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
      lastRead <= `PB_RST_ZERO;
    else if (portAccess)
      lastRead <= pinLevel;
  end

  // ****************************************
  // Mismatch on enabled input pins only
  // ****************************************
  always_comb
  begin
    differ   = (pinLevel ^ lastRead) & changeEnable & `PB_MSK_CHGEN;
    differ   = differ & direction;
    mismatch = |differ;
  end

endmodule // pb_change_detect

// ---- design/pb_port_b.sv ----
/*
  Port B pin control: output latch, direction, analog gating of digital
  input, weak pull-ups, change detection on the upper four pins and fuse
  driven relocation of peripheral pin functions, behind an AXI4-Lite slave.
  Assumes pin inputs are asynchronous and peripheral signals share clk.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pb_port_b_defs.svh"
module pb_port_b
  import pb_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b0
)(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic [`PB_AXI_AW-1:0]   awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`PB_AXI_AW-1:0]   araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic [7:0]              pinIn,
  output logic      [7:0]              pinOut,
  output logic      [7:0]              pinOe,
  output logic      [7:0]              pullupOn,
  input  wire logic                    highVoltageMode,
  input  wire logic                    serialDataOutput,
  input  wire logic                    serialOutEnable,
  input  wire logic                    compare2Out,
  input  wire logic                    compare2OutEnable,
  input  wire logic                    pwmOut2,
  input  wire logic                    pwmOut2Enable,
  input  wire logic                    pwmOut4,
  input  wire logic                    pwmOut4Enable,
  output logic                         serialOutOnPortB,
  output logic                         timer3ClockOnPortB,
  output logic                         timer3ClockInput,
  output logic                         compare2OnPortB,
  output logic                         compare2CaptureInput,
  output logic                         pwmOnOtherPorts,
  output logic                         irq
);

  // ****************************************
  // Declarations
  // ****************************************
  pb_rd_state_t          rdState;
  pb_wr_state_t          wrState;
  logic                  awHeld;
  logic                  wHeld;
  logic [`PB_AXI_AW-1:0] wrAddr;
  logic [7:0]            wrData;
  logic                  wrLane;
  logic                  doWrite;
  logic                  wrMapped;
  logic                  rdMapped;
  logic [7:0]            rdValue;
  logic                  portRead;
  logic                  portWrite;

  logic [7:0] analogSel;
  logic [7:0] intMain;
  logic [7:0] intSecond;
  logic [7:0] intThird;
  logic [7:0] changeEn;
  logic [7:0] outLatch;
  logic [7:0] slewCtl;
  logic [7:0] direction;
  logic [7:0] pullupEn;
  logic [7:0] fuseReloc;
  logic [7:0] fuseDebug;
  logic [7:0] irqStatus;
  logic [7:0] irqMask;
  logic [7:0] slewMask;

  logic [7:0] pinLevel;
  logic [7:0] levelsRead;
  logic [0:0] hvSync;
  logic       mismatch;
  logic       changeFlagClear;
  logic [7:0] next_pinOut;
  logic [7:0] next_pullupOn;

  assign slewMask = LARGE_PKG ? `PB_MSK_SLEW_L : `PB_MSK_SLEW_S;

  // ****************************************
  // Pin and mode synchronisers
  // ****************************************
  pb_pin_sync #(.WIDTH(8)) uPinSync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (pinIn),
    .syncOut (pinLevel)
  );

  pb_pin_sync #(.WIDTH(1)) uHvSync (
    .clk     (clk),
    .resetn  (resetn),
    .asyncIn (highVoltageMode),
    .syncOut (hvSync)
  );

  // ****************************************
  // Write channel
  // ****************************************
  assign awready = !awHeld && (wrState == PB_WR_IDLE);
  assign wready  = !wHeld && (wrState == PB_WR_IDLE);
  assign doWrite = awHeld && wHeld && (wrState == PB_WR_IDLE);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrState <= PB_WR_IDLE;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      wrAddr  <= '0;
      wrData  <= `PB_RST_ZERO;
      wrLane  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `PB_RESP_OKAY;
    end
    else
    begin
      case (wrState)
        PB_WR_IDLE:
        begin
          if (awvalid && awready)
          begin
            awHeld <= 1'b1;
            wrAddr <= awaddr;
          end
          if (wvalid && wready)
          begin
            wHeld  <= 1'b1;
            wrData <= wdata[7:0];
            wrLane <= wstrb[0];
          end
          if (doWrite)
          begin
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wrMapped ? `PB_RESP_OKAY : `PB_RESP_DECERR;
            wrState <= PB_WR_RESP;
          end
        end
        PB_WR_RESP:
        begin
          if (bready)
          begin
            bvalid  <= 1'b0;
            wrState <= PB_WR_IDLE;
          end
        end
        default:
          wrState <= PB_WR_IDLE;
      endcase
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic isMapped(input logic [`PB_AXI_AW-1:0] a);
    case (a)
      `PB_OFF_ANALOG, `PB_OFF_INTMAIN, `PB_OFF_INTSEC, `PB_OFF_INTTHIRD,
      `PB_OFF_CHGEN, `PB_OFF_LATCH, `PB_OFF_LEVELS, `PB_OFF_SLEW,
      `PB_OFF_DIR, `PB_OFF_PULLUP, `PB_OFF_FUSEREL, `PB_OFF_FUSEDBG,
      `PB_OFF_IRQSTAT, `PB_OFF_IRQMASK:
        isMapped = 1'b1;
      default:
        isMapped = 1'b0;
    endcase
  endfunction

  assign wrMapped = isMapped(wrAddr);
  assign rdMapped = isMapped(araddr);

  function automatic logic hit(input logic [`PB_AXI_AW-1:0] off,
                               input logic                  go);
    hit = go && (off == wrAddr);
  endfunction

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      analogSel <= `PB_RST_ANALOG;
      intMain   <= `PB_RST_ZERO;
      intSecond <= `PB_RST_INTSEC;
      intThird  <= `PB_RST_ZERO;
      changeEn  <= `PB_RST_ZERO;
      outLatch  <= `PB_RST_ZERO;
      slewCtl   <= `PB_RST_ZERO;
      direction <= `PB_RST_DIR;
      pullupEn  <= `PB_RST_ZERO;
      irqMask   <= `PB_RST_ZERO;
    end
    else if (doWrite && wrLane)
    begin
      if (hit(`PB_OFF_ANALOG, 1'b1))
        analogSel <= wrData & `PB_MSK_ANALOG;
      if (hit(`PB_OFF_INTMAIN, 1'b1))
        intMain <= wrData & `PB_MSK_INTMAIN;
      if (hit(`PB_OFF_INTSEC, 1'b1))
        intSecond <= wrData & `PB_MSK_INTSEC;
      if (hit(`PB_OFF_INTTHIRD, 1'b1))
        intThird <= wrData & `PB_MSK_INTTHIRD;
      if (hit(`PB_OFF_CHGEN, 1'b1))
        changeEn <= wrData & `PB_MSK_CHGEN;
      if (hit(`PB_OFF_LATCH, 1'b1) || hit(`PB_OFF_LEVELS, 1'b1))
        outLatch <= wrData;
      if (hit(`PB_OFF_SLEW, 1'b1))
        slewCtl <= wrData & slewMask;
      if (hit(`PB_OFF_DIR, 1'b1))
        direction <= wrData;
      if (hit(`PB_OFF_PULLUP, 1'b1))
        pullupEn <= wrData;
      if (hit(`PB_OFF_IRQMASK, 1'b1))
        irqMask <= wrData & `PB_MSK_IRQ;
    end
  end

  // ****************************************
  // Fuse registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fuseReloc <= `PB_RST_FUSEREL;
      fuseDebug <= `PB_RST_FUSEDBG;
    end
    else if (doWrite && wrLane)
    begin
      if (hit(`PB_OFF_FUSEREL, 1'b1))
        fuseReloc <= wrData & `PB_MSK_FUSEREL;
      if (hit(`PB_OFF_FUSEDBG, 1'b1))
      begin
        fuseDebug <= (wrData & `PB_MSK_FUSEDBG)
                   | (fuseDebug & ~`PB_MSK_FUSEDBG & ~(8'h01 << `PB_BIT_LVPEN));
        // Enable bit only moves while in high-voltage mode
        if (hvSync[0])
          fuseDebug[`PB_BIT_LVPEN] <= wrData[`PB_BIT_LVPEN];
        else
          fuseDebug[`PB_BIT_LVPEN] <= fuseDebug[`PB_BIT_LVPEN];
      end
    end
  end

  // ****************************************
  // Change detect and sticky flag
  // ****************************************
  assign portRead  = arvalid && arready && (araddr == `PB_OFF_LEVELS);
  assign portWrite = doWrite && (wrAddr == `PB_OFF_LEVELS);

  pb_change_detect uChange (
    .clk          (clk),
    .resetn       (resetn),
    .pinLevel     (levelsRead),
    .direction    (direction),
    .changeEnable (changeEn),
    .portAccess   (portRead || portWrite),
    .mismatch     (mismatch)
  );

  // Clear by W1C on status, or by writing zero to the flag bit
  assign changeFlagClear =
      (doWrite && wrLane && (wrAddr == `PB_OFF_IRQSTAT) && wrData[`PB_IRQ_CHANGE])
   || (doWrite && wrLane && (wrAddr == `PB_OFF_INTMAIN) && !wrData[`PB_BIT_CHGIF]);

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irqStatus <= `PB_RST_ZERO;
    else if (mismatch)
      irqStatus[`PB_IRQ_CHANGE] <= 1'b1;
    else if (changeFlagClear)
      irqStatus[`PB_IRQ_CHANGE] <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqMask) && intMain[`PB_BIT_CHGIE];
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign arready = (rdState == PB_RD_IDLE);

  always_comb
  begin
    case (araddr)
      `PB_OFF_ANALOG:   rdValue = analogSel;
      `PB_OFF_INTMAIN:  rdValue = intMain | irqStatus;
      `PB_OFF_INTSEC:   rdValue = intSecond;
      `PB_OFF_INTTHIRD: rdValue = intThird;
      `PB_OFF_CHGEN:    rdValue = changeEn;
      `PB_OFF_LATCH:    rdValue = outLatch;
      `PB_OFF_LEVELS:   rdValue = levelsRead;
      `PB_OFF_SLEW:     rdValue = slewCtl;
      `PB_OFF_DIR:      rdValue = direction;
      `PB_OFF_PULLUP:   rdValue = pullupEn;
      `PB_OFF_FUSEREL:  rdValue = fuseReloc;
      `PB_OFF_FUSEDBG:  rdValue = fuseDebug;
      `PB_OFF_IRQSTAT:  rdValue = irqStatus;
      `PB_OFF_IRQMASK:  rdValue = irqMask;
      default:          rdValue = `PB_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdState <= PB_RD_IDLE;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `PB_RESP_OKAY;
    end
    else
    begin
      case (rdState)
        PB_RD_IDLE:
        begin
          if (arvalid)
          begin
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rdValue};
            rresp   <= rdMapped ? `PB_RESP_OKAY : `PB_RESP_DECERR;
            rdState <= PB_RD_DATA;
          end
        end
        PB_RD_DATA:
        begin
          if (rready)
          begin
            rvalid  <= 1'b0;
            rdState <= PB_RD_IDLE;
          end
        end
        default:
          rdState <= PB_RD_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin datapath
  // ****************************************
  // Digital input is blanked for analog-selected input pins
  assign levelsRead = pinLevel & ~(analogSel & direction);

  always_comb
  begin
    next_pinOut = outLatch;
    if (!LARGE_PKG && pwmOut2Enable)
      next_pinOut[`PB_PIN_PWM2] = pwmOut2;
    if (!LARGE_PKG && pwmOut4Enable)
      next_pinOut[`PB_PIN_PWM4] = pwmOut4;
    if (!fuseReloc[`PB_BIT_CMP2MUX] && compare2OutEnable)
      next_pinOut[`PB_PIN_CMP2] = compare2Out;
    if (fuseReloc[`PB_BIT_SDOMUX] && serialOutEnable)
      next_pinOut[`PB_PIN_SDO] = serialDataOutput;
    next_pullupOn = pullupEn & direction;
    if (intSecond[`PB_BIT_PUDIS])
      next_pullupOn = `PB_RST_ZERO;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pinOut   <= `PB_RST_ZERO;
      pinOe    <= `PB_RST_ZERO;
      pullupOn <= `PB_RST_ZERO;
    end
    else
    begin
      pinOut   <= next_pinOut;
      pinOe    <= ~direction;
      pullupOn <= next_pullupOn;
    end
  end

  // ****************************************
  // Peripheral routing
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      serialOutOnPortB     <= 1'b0;
      timer3ClockOnPortB   <= 1'b0;
      timer3ClockInput     <= 1'b0;
      compare2OnPortB      <= 1'b0;
      compare2CaptureInput <= 1'b0;
      pwmOnOtherPorts      <= 1'b0;
    end
    else
    begin
      serialOutOnPortB     <= fuseReloc[`PB_BIT_SDOMUX];
      timer3ClockOnPortB   <= !fuseReloc[`PB_BIT_T3MUX];
      timer3ClockInput     <= !fuseReloc[`PB_BIT_T3MUX]
                              && levelsRead[`PB_PIN_T3CLK];
      compare2OnPortB      <= !fuseReloc[`PB_BIT_CMP2MUX];
      compare2CaptureInput <= !fuseReloc[`PB_BIT_CMP2MUX]
                              && levelsRead[`PB_PIN_CMP2];
      pwmOnOtherPorts      <= LARGE_PKG;
    end
  end

endmodule // pb_port_b

// ---- bench/pb_board.sv ----
/*
  Board model on the port B pins: resolves each pin from the port drive,
  a board driver, the weak pull-up, else a changing float level.
  Assumes one clock domain; pure combinational.
*/
`timescale 1ns/1ps
module pb_board (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupOn,
  input  wire logic [7:0] boardVal,
  input  wire logic [7:0] boardEn,
  output logic      [7:0] pinIn
);
  // Floating pin shows inverse of the port's drive data
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pinIn[i] = pinOe[i] ? pinOut[i] : boardEn[i] ? boardVal[i] :
                 pullupOn[i] ? 1'b1 : ~pinOut[i];
  end
endmodule // pb_board

// ---- bench/pb_port_b_assertions.sv ----
/*
  Port checker for pb_port_b: pin routing, pull-up and bus timing.
  Assumes binding to the top module, one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module pb_port_b_checker #(
  parameter bit LARGE_PKG = 1'b0
)(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [7:0]  pinOut,
  input wire logic [7:0]  pinOe,
  input wire logic [7:0]  pullupOn,
  input wire logic        serialDataOutput,
  input wire logic        serialOutEnable,
  input wire logic        pwmOut2,
  input wire logic        pwmOut2Enable,
  input wire logic        serialOutOnPortB,
  input wire logic        timer3ClockOnPortB,
  input wire logic        timer3ClockInput,
  input wire logic        compare2OnPortB,
  input wire logic        compare2CaptureInput,
  input wire logic        pwmOnOtherPorts,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************
  // Assertions
  // ****************
  property p_pull_out; (pullupOn & pinOe) == 8'h00; endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on driven pin");
  property p_pkg; $past(resetn) |-> pwmOnOtherPorts == LARGE_PKG; endproperty
  a_pkg: assert property (p_pkg) else $error("pwm routing flag wrong");
  property p_pwm2;
    $past(resetn) && $past(pwmOut2Enable) && !pwmOnOtherPorts && !$past(pwmOnOtherPorts)
      |-> pinOut[2] == $past(pwmOut2);
  endproperty
  a_pwm2: assert property (p_pwm2) else $error("pwm output 2 not on pin 2");
  property p_sdo;
    $past(resetn) && serialOutOnPortB && $past(serialOutOnPortB) && $past(serialOutEnable)
      |-> pinOut[3] == $past(serialDataOutput);
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial out not on pin 3");
  property p_t3;
    $past(resetn, 2) && !timer3ClockOnPortB && !$past(timer3ClockOnPortB)
      && !$past(timer3ClockOnPortB, 2) |-> !timer3ClockInput;
  endproperty
  a_t3: assert property (p_t3) else $error("timer3 clock input leaks");
  property p_c2;
    $past(resetn, 2) && !compare2OnPortB && !$past(compare2OnPortB)
      && !$past(compare2OnPortB, 2) |-> !compare2CaptureInput;
  endproperty
  a_c2: assert property (p_c2) else $error("capture input leaks");
  property p_rzero; rvalid |-> rdata[31:8] == 24'h000000; endproperty
  a_rzero: assert property (p_rzero) else $error("upper read bits set");
  property p_rlat; arvalid && arready |=> rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  c_sdo: cover property (serialOutOnPortB && serialOutEnable);
  c_t3: cover property (timer3ClockInput);
  c_pull: cover property (pullupOn != 8'h00);
endmodule // pb_port_b_checker

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for pb_port_b over AXI4-Lite with a board model.
  Assumes the design files and constants header are compiled first.
*/
`timescale 1ns/1ps
`define CK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, hv;
  logic sDat, sEn, c2, c2En, p2, p2En, p4, p4En;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic sOn, t3On, t3In, c2On, c2In, pOth;
  logic [7:0]  awaddr, araddr, pinIn, pinOut, pinOe, pullupOn, bVal, bEn, v;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int mismatches, compares, cyc;
  pb_port_b u_pb_port_b (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pinIn, .pinOut, .pinOe, .pullupOn, .highVoltageMode(hv),
    .serialDataOutput(sDat), .serialOutEnable(sEn), .compare2Out(c2),
    .compare2OutEnable(c2En), .pwmOut2(p2), .pwmOut2Enable(p2En), .pwmOut4(p4),
    .pwmOut4Enable(p4En), .serialOutOnPortB(sOn), .timer3ClockOnPortB(t3On),
    .timer3ClockInput(t3In), .compare2OnPortB(c2On), .compare2CaptureInput(c2In),
    .pwmOnOtherPorts(pOth), .irq);
  pb_board u_pb_board (.pinOut, .pinOe, .pullupOn, .boardVal(bVal), .boardEn(bEn), .pinIn);
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ****************
  // Bus tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit ad, dd;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!dd && wready) begin dd = 1; wvalid <= 0; end
    end
    while (!bvalid) @(posedge clk);
    r = bresp; bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clk);
    v = rdata[7:0]; r = rresp; rready <= 0;
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000) begin mismatches++; close_out(); end
  end
  // ****************
  // Tests
  // ****************
  initial
  begin
    logic [7:0] ra[5] = '{8'h00, 8'h20, 8'h08, 8'h28, 8'h2c};
    logic [7:0] rv[5] = '{8'h3f, 8'hff, 8'hf5, 8'hd3, 8'h85};
    {resetn, awvalid, wvalid, bready, arvalid, rready, hv} = '0;
    {sDat, sEn, c2, c2En, p2, p2En, p4, p4En} = '0;
    {awaddr, araddr, wdata, bVal, bEn} = '0;
    wstrb = 4'h1;
    repeat (4) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 5; i++) begin rd(ra[i]); `CK(v, rv[i]) end
    rd(8'h38); `CK(r, 2'b11)
    `CK(v, 8'h00)
    wr(8'h3c, 8'h00); `CK(r, 2'b11)
    wr(8'h10, 8'hff); `CK(r, 2'b00)
    rd(8'h10); `CK(v, 8'hf0)
    wr(8'h2c, 8'h81); rd(8'h2c); `CK(v, 8'h85)
    hv <= 1; repeat (6) @(posedge clk);
    wr(8'h2c, 8'h81); rd(8'h2c); `CK(v, 8'h81)
    hv <= 0;
    wr(8'h20, 8'hf0); wr(8'h14, 8'ha5); wr(8'h24, 8'hff); wr(8'h08, 8'h75);
    repeat (2) @(posedge clk);
    `CK(pinOe, 8'h0f)
    `CK(pinOut & 8'h0f, 8'h05)
    `CK(pullupOn, 8'hf0)
    wr(8'h08, 8'hf5); repeat (2) @(posedge clk);
    `CK(pullupOn, 8'h00)
    wr(8'h20, 8'hff); bVal <= 8'h5a; bEn <= 8'hff; repeat (6) @(posedge clk);
    rd(8'h18); `CK(v, 8'h40)
    wr(8'h00, 8'h00); rd(8'h18); `CK(v, 8'h5a)
    wr(8'h04, 8'h08); wr(8'h34, 8'h01); rd(8'h18);
    bVal <= 8'h1a; repeat (8) @(posedge clk);
    `CK(irq, 1'b1)
    rd(8'h04); `CK(v, 8'h09)
    wr(8'h34, 8'h00); repeat (2) @(posedge clk);
    `CK(irq, 1'b0)
    wr(8'h34, 8'h01); rd(8'h18); wr(8'h30, 8'h01); repeat (2) @(posedge clk);
    `CK(irq, 1'b0)
    wr(8'h20, 8'h7f); rd(8'h18); wr(8'h14, 8'h25); repeat (8) @(posedge clk);
    `CK(irq, 1'b0)
    wr(8'h20, 8'h00); sEn <= 1; sDat <= 1; p2En <= 1; p2 <= 1; p4En <= 1; p4 <= 1;
    repeat (3) @(posedge clk);
    `CK(sOn, 1'b1)
    `CK(pinOut[3], 1'b1)
    `CK(pinOut[2], 1'b1)
    `CK(pinOut[4], 1'b1)
    `CK(pOth, 1'b0)
    wr(8'h28, 8'h82); wr(8'h20, 8'h20); bVal <= 8'h20; c2En <= 1; c2 <= 1;
    repeat (8) @(posedge clk);
    `CK(sOn, 1'b0)
    `CK(c2On, 1'b1)
    `CK(t3On, 1'b1)
    `CK(t3In, 1'b1)
    `CK(pinOut[3], 1'b1)
    `CK(c2In, 1'b1)
    close_out();
  end
endmodule // tb_top
bind pb_port_b pb_port_b_checker #(.LARGE_PKG(LARGE_PKG)) u_pb_port_b_checker (.clk, .resetn,
  .pinOut, .pinOe, .pullupOn, .serialDataOutput, .serialOutEnable, .pwmOut2, .pwmOut2Enable,
  .serialOutOnPortB, .timer3ClockOnPortB, .timer3ClockInput, .compare2OnPortB,
  .compare2CaptureInput, .pwmOnOtherPorts, .arvalid, .arready, .rvalid, .rdata);
